// >>> pmt_pkg.sv
// Package for the eight-bit period-match timer: register map, fields, resets, counts.
// Assumes a single 100 MHz clock domain and the plain register port of the top module.
package pmt_pkg;
	localparam logic [7:0] PMT_ADDR_TICK_COUNT = 8'h11;
	localparam logic [7:0] PMT_ADDR_TIMER_CONTROL = 8'h12;
	localparam logic [7:0] PMT_ADDR_PERIOD_LIMIT = 8'h91;
	localparam logic [7:0] PMT_ADDR_IRQ_STATUS = 8'hA0;
	localparam logic [7:0] PMT_ADDR_IRQ_MASK = 8'hA1;

	localparam int PMT_CTRL_MDS_LSB = 3;
	localparam int PMT_CTRL_EN_BIT = 2;
	localparam int PMT_CTRL_IDS_LSB = 0;

	localparam logic [7:0] PMT_TICK_COUNT_RST = 8'h00;
	localparam logic [7:0] PMT_PERIOD_LIMIT_RST = 8'hFF;
	localparam logic [6:0] PMT_CONTROL_RST = 7'h00;
	localparam logic [0:0] PMT_IRQ_MASK_RST = 1'h0;

	localparam int PMT_INSTR_CLK_DIV = 4;
	localparam logic [3:0] PMT_IN_DIV_TERM_1 = 4'h0;
	localparam logic [3:0] PMT_IN_DIV_TERM_4 = 4'h3;
	localparam logic [3:0] PMT_IN_DIV_TERM_16 = 4'hF;

	typedef struct packed {
		logic [3:0] match_divider_select;
		logic count_enable;
		logic [1:0] input_divider_select;
	} pmt_control_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} pmt_bus_req_t;
endpackage

// >>> pmt_timer.sv
// Eight-bit period-match timer with input divider, match divider and interrupt.
// Assumes one clock at 100 MHz; software uses a plain one-cycle strobe register port.
`timescale 1ns/10ps

// Summary of operation
// - Count source is the instruction clock, system clock over four, via input divider.
// - Input divider select: 00 divides by 1, 01 by 4, 10 and 11 by 16.
// - Count rises from zero each divided tick, compared always with the period.
// - On equality the count goes to zero at the next tick instead of rising.
// - Each match advances the match divider; ratio is select value plus one.
// - Each match divider output pulse sets the period-match flag.
// - Reset loads count with zero and period with all ones.
// - Software may read count and period and write period at any time; count writes are ignored while disabled.
// - Control bit 2 runs the timer when set, stops it when clear.
// - All three divider counters (instruction, input, match) clear when disabled and on every reset.
// - Control writes leave count alone; count held zero while disabled.
// - Control: bits 6..3 match select, bit 2 enable, bits 1..0 input select; bit 7 zero.
module pmt_timer
	import pmt_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic irq,
	output logic period_match_flag
);
	pmt_bus_req_t req;
	pmt_control_t timer_control;
	logic [7:0] tick_count;
	logic [7:0] period_limit;
	logic [1:0] instr_div;
	logic [3:0] in_div;
	logic [3:0] match_div;
	logic irq_mask;
	logic instr_tick;
	logic count_tick;
	logic match;
	logic match_out;
	logic [3:0] in_term;
	logic [1:0] next_instr_div;
	logic [3:0] next_in_div;
	logic [7:0] next_tick_count;
	logic [7:0] next_period_limit;
	pmt_control_t next_timer_control;
	logic [3:0] next_match_div;
	logic next_period_match_flag;
	logic next_irq_mask;
	logic [7:0] next_reg_rdata;
	logic wr_count;
	logic wr_period;
	logic wr_control;
	logic wr_status;
	logic wr_mask;
	logic clear_flag;
	logic div_clear;

	assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

	function automatic logic [3:0] in_div_term(input logic [1:0] sel);
		case (sel)
			2'h0: in_div_term = PMT_IN_DIV_TERM_1;
			2'h1: in_div_term = PMT_IN_DIV_TERM_4;
			default: in_div_term = PMT_IN_DIV_TERM_16;
		endcase
	endfunction

	function automatic logic hit(input pmt_bus_req_t r, input logic [7:0] a);
		hit = r.wr && (r.addr == a);
	endfunction

	// Register read multiplexer; unmapped addresses read zero
	function automatic logic [7:0] read_mux(
		input logic [7:0] a,
		input logic [7:0] cnt,
		input logic [7:0] per,
		input pmt_control_t ctl,
		input logic flag,
		input logic msk
	);
		case (a)
			PMT_ADDR_TICK_COUNT: read_mux = cnt;
			PMT_ADDR_PERIOD_LIMIT: read_mux = per;
			PMT_ADDR_TIMER_CONTROL: read_mux = {1'h0, ctl};
			PMT_ADDR_IRQ_STATUS: read_mux = {7'h00, flag};
			PMT_ADDR_IRQ_MASK: read_mux = {7'h00, msk};
			default: read_mux = 8'h00;
		endcase
	endfunction

	// Write decodes
	assign wr_count = hit(req, PMT_ADDR_TICK_COUNT);
	assign wr_period = hit(req, PMT_ADDR_PERIOD_LIMIT);
	assign wr_control = hit(req, PMT_ADDR_TIMER_CONTROL);
	assign wr_status = hit(req, PMT_ADDR_IRQ_STATUS);
	assign wr_mask = hit(req, PMT_ADDR_IRQ_MASK);
	assign clear_flag = wr_status && req.wdata[0];
	assign div_clear = !timer_control.count_enable;

	assign in_term = in_div_term(timer_control.input_divider_select);
	assign instr_tick = timer_control.count_enable &&
		(instr_div == 2'(PMT_INSTR_CLK_DIV - 1));
	assign count_tick = instr_tick && (in_div == in_term);
	assign match = (tick_count == period_limit);
	assign match_out = count_tick && match &&
		(match_div == timer_control.match_divider_select);

	// Instruction clock: system clock over four, cleared while disabled
	always_comb begin
		next_instr_div = instr_div;
		if (div_clear) begin
			next_instr_div = 2'h0;
		end else begin
			next_instr_div = instr_div + 2'h1;
		end
	end

	// Input divider wraps at the selected terminal count
	always_comb begin
		next_in_div = in_div;
		if (div_clear) begin
			next_in_div = 4'h0;
		end else if (instr_tick) begin
			if (in_div >= in_term) begin
				next_in_div = 4'h0;
			end else begin
				next_in_div = in_div + 4'h1;
			end
		end
	end

	// Count: software write beats a same-cycle tick
	always_comb begin
		next_tick_count = tick_count;
		if (div_clear) begin
			next_tick_count = PMT_TICK_COUNT_RST;
		end else if (wr_count) begin
			next_tick_count = req.wdata;
		end else if (count_tick) begin
			if (match) begin
				next_tick_count = 8'h00;
			end else begin
				next_tick_count = tick_count + 8'h01;
			end
		end
	end

	always_comb begin
		next_period_limit = period_limit;
		if (wr_period) begin
			next_period_limit = req.wdata;
		end
	end

	// Control writes leave the count untouched
	always_comb begin
		next_timer_control = timer_control;
		if (wr_control) begin
			next_timer_control = pmt_control_t'(req.wdata[6:0]);
		end
	end

	// Match divider restarts once the selected ratio is reached
	always_comb begin
		next_match_div = match_div;
		if (div_clear) begin
			next_match_div = 4'h0;
		end else if (count_tick && match) begin
			if (match_div >= timer_control.match_divider_select) begin
				next_match_div = 4'h0;
			end else begin
				next_match_div = match_div + 4'h1;
			end
		end
	end

	// Sticky flag; a new event wins over a same-cycle clear
	always_comb begin
		next_period_match_flag = period_match_flag;
		if (match_out) begin
			next_period_match_flag = 1'h1;
		end else if (clear_flag) begin
			next_period_match_flag = 1'h0;
		end
	end

	always_comb begin
		next_irq_mask = irq_mask;
		if (wr_mask) begin
			next_irq_mask = req.wdata[0];
		end
	end

	// Read data stands only in the cycle after the strobe
	always_comb begin
		next_reg_rdata = 8'h00;
		if (req.rd) begin
			next_reg_rdata = read_mux(req.addr, tick_count, period_limit, timer_control,
				period_match_flag, irq_mask);
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			instr_div <= 2'h0;
		end else begin
			instr_div <= next_instr_div;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			in_div <= 4'h0;
		end else begin
			in_div <= next_in_div;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tick_count <= PMT_TICK_COUNT_RST;
		end else begin
			tick_count <= next_tick_count;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			period_limit <= PMT_PERIOD_LIMIT_RST;
		end else begin
			period_limit <= next_period_limit;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			timer_control <= PMT_CONTROL_RST;
		end else begin
			timer_control <= next_timer_control;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			match_div <= 4'h0;
		end else begin
			match_div <= next_match_div;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			period_match_flag <= 1'h0;
		end else begin
			period_match_flag <= next_period_match_flag;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_mask <= PMT_IRQ_MASK_RST[0];
		end else begin
			irq_mask <= next_irq_mask;
		end
	end

	assign irq = period_match_flag && irq_mask;

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= next_reg_rdata;
		end
	end
endmodule

// >>> pmt_timer_checker.sv
// Checker on the pmt_timer ports.
// Bound into pmt_timer; one clock, async low reset.
`timescale 1ns/10ps
module pmt_timer_checker (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic irq,
	input wire logic period_match_flag
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);
	logic en, clr;
	assign clr = reg_wr && reg_addr == 8'hA0 && reg_wdata[0];
	always_ff @(posedge clk or negedge arst_n)
		if (!arst_n) en <= 1'h0;
		else if (reg_wr && reg_addr == 8'h12) en <= reg_wdata[2];
	AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("rd");
	AST_IRQ: assert property (irq |-> period_match_flag) else $error("irq");
	AST_STICKY: assert property ($past(period_match_flag) && !$past(clr)
		|-> period_match_flag) else $error("flag lost");
	AST_BIT7: assert property ($past(reg_rd) && $past(reg_addr) == 8'h12 |-> !reg_rdata[7])
		else $error("bit7");
	AST_RISE_EN: assert property ($rose(period_match_flag) |-> $past(en, 2))
		else $error("rise");
	AST_DIS_ZERO: assert property (reg_wr && reg_addr == 8'h12 && !reg_wdata[2]
		##2 reg_rd && reg_addr == 8'h11 |=> reg_rdata == 8'h00) else $error("cz");
	AST_CNT_WR: assert property (en && reg_wr && reg_addr == 8'h11 ##2 reg_rd && reg_addr == 8'h11
		|=> reg_rdata inside {$past(reg_wdata, 3), $past(reg_wdata, 3) + 8'h01}) else $error("cw");
	AST_PR_WR: assert property (reg_wr && reg_addr == 8'h91 ##2 reg_rd && reg_addr == 8'h91
		|=> reg_rdata == $past(reg_wdata, 3)) else $error("pw");
	cover property ($rose(period_match_flag));
	cover property (irq);
	cover property ($fell(period_match_flag));
endmodule
bind pmt_timer pmt_timer_checker pmt_timer_checker_i (.clk, .arst_n, .reg_addr, .reg_wdata,
	.reg_wr, .reg_rd, .reg_rdata, .irq, .period_match_flag);

// >>> test_pmt_timer.sv
// Bench for pmt_timer: register, rate and match tests.
// Drives the register port at rising edges; checker is bound.
`timescale 1ns/10ps
module test_pmt_timer;
	logic clk = 1'h0, arst_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, irq, period_match_flag;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
	int fails = 0, n_checks = 0, cyc = 0;
	pmt_timer pmt_timer_i (.clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .irq, .period_match_flag);
	always #5 clk = ~clk;
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		n_checks++;
		if (g !== e) begin fails++; $display("MISMATCH %0t got %h exp %h", $time, g, e); end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'h1, a, v};
		@(posedge clk) reg_wr <= 1'h0;
	endtask
	task automatic rc(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk) {reg_rd, reg_addr} <= {1'h1, a};
		@(posedge clk) reg_rd <= 1'h0;
		#1 chk(reg_rdata, e);
	endtask
	task automatic results;
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	always @(posedge clk) if (++cyc == 5000) begin fails++; results(); end
	initial begin
		repeat (5) @(posedge clk);
		arst_n <= 1'h1;
		rc(8'h91, 8'hFF);
		rc(8'h55, 8'h00);
		wr(8'h91, 8'h5A);
		rc(8'h91, 8'h5A);
		wr(8'h12, 8'hFF);
		rc(8'h12, 8'h7F);
		wr(8'h11, 8'h10);
		rc(8'h11, 8'h10);
		wr(8'h12, 8'h00);
		rc(8'h11, 8'h00);
		$display("register test end");
		for (int k = 0; k < 4; k++) begin
			wr(8'h12, 8'h04 | 8'(k));
			repeat (42 * (k == 0 ? 1 : k == 1 ? 4 : 16) - 1) @(posedge clk);
			rc(8'h11, 8'h0A);
			wr(8'h12, 8'h00);
		end
		$display("rate test end");
		wr(8'h91, 8'h02);
		wr(8'h12, 8'h0C);
		repeat (17) @(posedge clk);
		rc(8'h11, 8'h01);
		rc(8'hA0, 8'h00);
		repeat (2) @(posedge clk);
		rc(8'hA0, 8'h01);
		chk({7'h00, period_match_flag}, 8'h01);
		chk({7'h00, irq}, 8'h00);
		wr(8'hA1, 8'h01);
		#1 chk({7'h00, irq}, 8'h01);
		wr(8'hA0, 8'h01);
		rc(8'hA0, 8'h00);
		repeat (16) @(posedge clk);
		rc(8'hA0, 8'h01);
		$display("match test end");
		results();
	end
endmodule
